// >>> src/cls_consts.svh
// Constants of the carrier loop and output statistics block.
`ifndef CLS_CONSTS_SVH
`define CLS_CONSTS_SVH
`define CLS_CLK_PER_SYM        2
`define CLS_INIT_SHORT_SYMS    16384
`define CLS_INIT_LONG_SYMS     32768
`define CLS_AFC_AVG_SHORT      16
`define CLS_AFC_AVG_LONG       64
`define CLS_AGC_PERIOD_SYMS    256
`define CLS_CMA_SHIFT_BASE     4'd10
`define CLS_DD_SHIFT_BASE      4'd13
`define CLS_CODE_IDLE          3'h0
`define CLS_CODE_INIT          3'h1
`define CLS_CODE_AFC           3'h2
`define CLS_CODE_SCAN          3'h3
`define CLS_CODE_CORNER        3'h4
`define CLS_CODE_DDPULL        3'h6
`define CLS_CODE_LOCK          3'h7
`define CLS_ADDR_STATUS        2'h0
`define CLS_ADDR_CLEAR         2'h1
`define CLS_ADDR_ENABLE        2'h2
`define CLS_IRQ_LOCK_GAIN      0
`define CLS_IRQ_LOCK_LOSS      1
`define CLS_IRQ_PULL_FAIL      2
`define CLS_IRQ_WIDTH          3
`define CLS_IRQ_RESET          3'h0
`endif

// >>> src/cls_pkg.sv
// Types of the carrier loop and output statistics block.
package cls_pkg;
   typedef enum logic [2:0] {
      CLS_IDLE, CLS_INIT, CLS_AFC, CLS_SCAN, CLS_CORNER, CLS_DDPULL, CLS_LOCK
   } cls_state_t;
   typedef enum logic [1:0] {
      CLS_BW_PULL_NARROW, CLS_BW_PULL_WIDE, CLS_BW_TRACK_NARROW, CLS_BW_TRACK_WIDE
   } cls_bw_t;
   typedef struct packed {
      logic initial_long;
      logic use_afc;
      logic afc_avg_long;
      logic pullin_wide;
      logic tracking_wide;
      logic [1:0] step_constmod;
      logic [1:0] step_decision;
   } cls_cfg_t;
   typedef struct packed {
      logic afc_calc;
      logic pull_ok;
      logic pull_fail;
      logic track_lost;
   } cls_ev_t;
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cls_bus_t;
endpackage

// >>> src/cls_carrier_loop.sv
// Carrier loop sequencer with received data output, error statistics and gain pulse.
// What this block does
// - One setting picks initial period length: 16384 or 32768 symbols.
// - Timing loop lock moves idle to initial, equalizer into constant modulus mode.
// - Frequency estimate by averaging only when the method bit is one.
// - Without averaging, each failed pull-in bumps the scan counter by one.
// - Averaging spans 16 computations, or 64 when its bit is one.
// - Pull-in bandwidth is 0.0015, or 0.003 when its bit is one.
// - Tracking bandwidth is 0.01, or 0.02 when its bit is one.
// - Constant modulus step is 1/1024 to 1/128 by two-bit setting.
// - Decision-directed step is 1/8192 to 1/1024 by two-bit setting.
// - Received bytes leave on eight bits with a valid flag.
// - Trellis error estimate is reported as a 16-bit count.
// - Corrected count is 32 bits on two 16-bit halves.
// - Gain pulse period is 256 symbols, width follows input level.
// - Three-bit state output refreshed each symbol with the fixed codes.
// - Restart returns to idle; acquisition waits for timing lock again.
// - Lock flag high while locked, refreshed every two clock cycles.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "cls_consts.svh"
`default_nettype none
module cls_carrier_loop #(
   parameter int INIT_SHORT_SYMS = `CLS_INIT_SHORT_SYMS,
   parameter int INIT_LONG_SYMS  = `CLS_INIT_LONG_SYMS,
   parameter int SCAN_WIDTH      = 8
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              restart,
   input  wire logic              timing_loop_locked,
   input  wire cls_pkg::cls_cfg_t cfg,
   input  wire cls_pkg::cls_ev_t  ev,
   input  wire cls_pkg::cls_bus_t bus,
   input  wire logic [7:0]        rx_byte_in,
   input  wire logic              rx_byte_valid_in,
   input  wire logic              trellis_error,
   input  wire logic              rs_corr_valid,
   input  wire logic [7:0]        rs_corr_add,
   input  wire logic [7:0]        signal_level,
   output logic [7:0]             bus_rdata,
   output logic                   irq,
   output logic [2:0]             carrier_loop_state,
   output logic                   carrier_loop_locked,
   output logic                   eq_constmod,
   output logic [3:0]             eq_step_shift,
   output cls_pkg::cls_bw_t       loop_bw,
   output logic                   phase_error_hold,
   output logic [SCAN_WIDTH-1:0]  scan_offset,
   output logic [7:0]             rx_out_byte,
   output logic                   rx_out_valid,
   output logic [15:0]            trellis_error_estimate,
   output logic [15:0]            rs_corrected_count_hi,
   output logic [15:0]            rs_corrected_count_lo,
   output logic                   gain_control_pulse
);
   import cls_pkg::*;

   if (INIT_SHORT_SYMS < 1 || INIT_SHORT_SYMS > 65536 || INIT_LONG_SYMS < 1
       || INIT_LONG_SYMS > 65536 || SCAN_WIDTH < 1) begin
      $error("cls_carrier_loop: unsupported parameter values");
   end

   cls_state_t                   state;
   logic                         sym_phase;
   logic                         sym_tick;
   logic [16:0]                  init_cnt;
   logic [16:0]                  init_last;
   logic [6:0]                   avg_cnt;
   logic [6:0]                   avg_last;
   logic                         fail_path;
   logic [`CLS_IRQ_WIDTH-1:0]    ev_irq;
   logic [`CLS_IRQ_WIDTH-1:0]    status;
   logic [`CLS_IRQ_WIDTH-1:0]    enable;
   logic [`CLS_IRQ_WIDTH-1:0]    next_status;
   logic [31:0]                  rs_count;
   logic [31:0]                  next_rs_count;
   logic [7:0]                   agc_sym;
   logic [7:0]                   agc_level;
   logic [2:0]                   next_code;

   // Symbol rate strobe: one output symbol every two clock cycles.
   always_ff @(posedge clk) begin
      if (rst) begin
         sym_phase <= 1'b0;
      end else begin
         sym_phase <= ~sym_phase;
      end
   end
   assign sym_tick = sym_phase;

   assign init_last = cfg.initial_long ? 17'(INIT_LONG_SYMS - 1)
                                       : 17'(INIT_SHORT_SYMS - 1);
   assign avg_last  = cfg.afc_avg_long ? 7'(`CLS_AFC_AVG_LONG - 1)
                                       : 7'(`CLS_AFC_AVG_SHORT - 1);
   assign fail_path = ((state == CLS_CORNER || state == CLS_DDPULL) && ev.pull_fail)
                      || (state == CLS_LOCK && ev.track_lost);

   // Acquisition sequencer.
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         state <= CLS_IDLE;
      end else begin
         unique case (state)
            CLS_IDLE: begin
               if (timing_loop_locked) begin
                  state <= CLS_INIT;
               end
            end
            CLS_INIT: begin
               if (sym_tick && init_cnt == init_last) begin
                  state <= cfg.use_afc ? CLS_AFC : CLS_SCAN;
               end
            end
            CLS_AFC: begin
               if (ev.afc_calc && avg_cnt == avg_last) begin
                  state <= CLS_CORNER;
               end
            end
            CLS_SCAN: begin
               if (sym_tick) begin
                  state <= CLS_CORNER;
               end
            end
            CLS_CORNER: begin
               if (ev.pull_ok) begin
                  state <= CLS_DDPULL;
               end else if (ev.pull_fail) begin
                  state <= cfg.use_afc ? CLS_AFC : CLS_SCAN;
               end
            end
            CLS_DDPULL: begin
               if (ev.pull_ok) begin
                  state <= CLS_LOCK;
               end else if (ev.pull_fail) begin
                  state <= cfg.use_afc ? CLS_AFC : CLS_SCAN;
               end
            end
            CLS_LOCK: begin
               if (ev.track_lost) begin
                  state <= cfg.use_afc ? CLS_AFC : CLS_SCAN;
               end
            end
         endcase
      end
   end

   // Initial period counter in symbols.
   always_ff @(posedge clk) begin
      if (rst || state != CLS_INIT) begin
         init_cnt <= 17'h0;
      end else if (sym_tick) begin
         init_cnt <= init_cnt + 17'h1;
      end
   end

   // Count of frequency computations averaged in the estimate period.
   always_ff @(posedge clk) begin
      if (rst || state != CLS_AFC) begin
         avg_cnt <= 7'h0;
      end else if (ev.afc_calc) begin
         avg_cnt <= avg_cnt + 7'h1;
      end
   end

   // Scan counter gives a new trial offset after every failed pull-in or loss of track, only when averaging is off.
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         scan_offset <= '0;
      end else if (fail_path && !cfg.use_afc) begin
         scan_offset <= scan_offset + SCAN_WIDTH'(1);
      end
   end

   always_comb begin
      unique case (state)
         CLS_IDLE:   next_code = `CLS_CODE_IDLE;
         CLS_INIT:   next_code = `CLS_CODE_INIT;
         CLS_AFC:    next_code = `CLS_CODE_AFC;
         CLS_SCAN:   next_code = `CLS_CODE_SCAN;
         CLS_CORNER: next_code = `CLS_CODE_CORNER;
         CLS_DDPULL: next_code = `CLS_CODE_DDPULL;
         CLS_LOCK:   next_code = `CLS_CODE_LOCK;
         default:    next_code = `CLS_CODE_IDLE;
      endcase
   end

   // Status and lock flag refreshed once per output symbol.
   always_ff @(posedge clk) begin
      if (rst) begin
         carrier_loop_state  <= `CLS_CODE_IDLE;
         carrier_loop_locked <= 1'b0;
      end else if (sym_tick) begin
         carrier_loop_state  <= next_code;
         carrier_loop_locked <= (state == CLS_LOCK);
      end
   end

   // Equalizer mode, step size and loop bandwidth selection.
   always_ff @(posedge clk) begin
      if (rst) begin
         eq_constmod      <= 1'b0;
         eq_step_shift    <= `CLS_CMA_SHIFT_BASE;
         loop_bw          <= CLS_BW_PULL_NARROW;
         phase_error_hold <= 1'b1;
      end else begin
         eq_constmod      <= (state != CLS_IDLE && state != CLS_LOCK);
         phase_error_hold <= (state == CLS_IDLE || state == CLS_INIT);
         if (state == CLS_LOCK) begin
            eq_step_shift <= `CLS_DD_SHIFT_BASE - {2'b00, cfg.step_decision};
            loop_bw <= cfg.tracking_wide ? CLS_BW_TRACK_WIDE
                                         : CLS_BW_TRACK_NARROW;
         end else begin
            eq_step_shift <= `CLS_CMA_SHIFT_BASE - {2'b00, cfg.step_constmod};
            loop_bw <= cfg.pullin_wide ? CLS_BW_PULL_WIDE
                                       : CLS_BW_PULL_NARROW;
         end
      end
   end

   // Received byte output stage.
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_out_byte  <= 8'h0;
         rx_out_valid <= 1'b0;
      end else begin
         rx_out_valid <= rx_byte_valid_in;
         if (rx_byte_valid_in) begin
            rx_out_byte <= rx_byte_in;
         end
      end
   end

   // Trellis error estimate saturates rather than wrapping.
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         trellis_error_estimate <= 16'h0;
      end else if (trellis_error && trellis_error_estimate != 16'hffff) begin
         trellis_error_estimate <= trellis_error_estimate + 16'h1;
      end
   end

   assign next_rs_count = rs_corr_valid ? rs_count + {24'h0, rs_corr_add} : rs_count;

   // Corrected count and both output halves load from one sum in one cycle.
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         rs_count              <= 32'h0;
         rs_corrected_count_hi <= 16'h0;
         rs_corrected_count_lo <= 16'h0;
      end else begin
         rs_count              <= next_rs_count;
         rs_corrected_count_hi <= next_rs_count[31:16];
         rs_corrected_count_lo <= next_rs_count[15:0];
      end
   end

   // Gain pulse: level latched at each period start, high while the symbol count is below it.
   always_ff @(posedge clk) begin
      if (rst) begin
         agc_sym           <= 8'h0;
         agc_level         <= 8'h0;
         gain_control_pulse <= 1'b0;
      end else begin
         if (sym_tick) begin
            agc_sym <= agc_sym + 8'h1;
            if (agc_sym == 8'(`CLS_AGC_PERIOD_SYMS - 1)) begin
               agc_level <= signal_level;
            end
         end
         gain_control_pulse <= (agc_sym < agc_level);
      end
   end

   // Interrupt events, sticky status, enable and clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         ev_irq <= `CLS_IRQ_RESET;
      end else begin
         ev_irq[`CLS_IRQ_LOCK_GAIN] <= (state == CLS_DDPULL) && ev.pull_ok && !restart;
         ev_irq[`CLS_IRQ_LOCK_LOSS] <= (state == CLS_LOCK) && (ev.track_lost || restart);
         ev_irq[`CLS_IRQ_PULL_FAIL] <= fail_path && (state != CLS_LOCK);
      end
   end

   always_comb begin
      next_status = status;
      if (bus.wr && bus.addr == `CLS_ADDR_CLEAR) begin
         next_status = status & ~bus.wdata[`CLS_IRQ_WIDTH-1:0];
      end
      next_status = next_status | ev_irq;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status <= `CLS_IRQ_RESET;
         enable <= `CLS_IRQ_RESET;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         if (bus.wr && bus.addr == `CLS_ADDR_ENABLE) begin
            enable <= bus.wdata[`CLS_IRQ_WIDTH-1:0];
         end
         irq <= |(next_status & ((bus.wr && bus.addr == `CLS_ADDR_ENABLE)
                               ? bus.wdata[`CLS_IRQ_WIDTH-1:0] : enable));
      end
   end

   // Register read port, data one cycle after the strobe.
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_rdata <= 8'h0;
      end else if (bus.rd) begin
         unique case (bus.addr)
            `CLS_ADDR_STATUS: bus_rdata <= {5'h0, status};
            `CLS_ADDR_ENABLE: bus_rdata <= {5'h0, enable};
            default:          bus_rdata <= 8'h0;
         endcase
      end else begin
         bus_rdata <= 8'h0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_wake;
      state == CLS_IDLE && timing_loop_locked && !restart;
   endsequence
   sequence s_leave_init;
      state == CLS_INIT ##1 (state == CLS_AFC || state == CLS_SCAN);
   endsequence

   property p_wake;
      s_wake |=> state == CLS_INIT ##1 eq_constmod;
   endproperty
   a_wake: assert property (p_wake) else $error("idle did not move to initial");

   property p_init_len;
      s_leave_init |-> $past(init_cnt) == $past(init_last) && $past(sym_tick);
   endproperty
   a_init_len: assert property (p_init_len) else $error("initial period cut short");

   property p_method;
      $rose(state == CLS_AFC) |-> cfg.use_afc;
   endproperty
   a_method: assert property (p_method) else $error("averaging used while off");

   property p_scan_step;
      fail_path && !cfg.use_afc && !restart |=> scan_offset == $past(scan_offset) + 1'b1;
   endproperty
   a_scan_step: assert property (p_scan_step) else $error("scan counter not bumped");

   property p_avg;
      state == CLS_AFC ##1 state == CLS_CORNER |-> $past(avg_cnt) == avg_last;
   endproperty
   a_avg: assert property (p_avg) else $error("wrong averaging length");

   property p_step;
      state == CLS_LOCK ##1 state == CLS_LOCK
         |-> eq_step_shift == `CLS_DD_SHIFT_BASE - {2'b00, $past(cfg.step_decision)};
   endproperty
   a_step: assert property (p_step) else $error("decision step wrong");

   property p_lock_flag;
      sym_tick |=> carrier_loop_locked == ($past(state) == CLS_LOCK);
   endproperty
   a_lock_flag: assert property (p_lock_flag) else $error("lock flag and state disagree");

   sequence s_restart_held;
      restart ##1 restart;
   endsequence
   property p_restart;
      s_restart_held |=> state == CLS_IDLE ##1 carrier_loop_state == `CLS_CODE_IDLE;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not reach idle");

   property p_rs_pair;
      rs_corr_valid && !restart |=> {rs_corrected_count_hi, rs_corrected_count_lo}
         == $past(rs_count) + 32'($past(rs_corr_add));
   endproperty
   a_rs_pair: assert property (p_rs_pair) else $error("count halves torn");

   property p_rx;
      rx_byte_valid_in |=> rx_out_valid && rx_out_byte == $past(rx_byte_in);
   endproperty
   a_rx: assert property (p_rx) else $error("received byte lost");

   property p_agc_low;
      agc_level == 8'h0 && $stable(agc_level) |=> !gain_control_pulse;
   endproperty
   a_agc_low: assert property (p_agc_low) else $error("pulse high at zero level");

endmodule
`default_nettype wire

// >>> sim/cls_sink_model.sv
// Behavioural model of the downstream byte sink and the gain control circuit.
`timescale 1ns/1ps
`default_nettype none
module cls_sink_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] rx_out_byte,
   input  wire logic       rx_out_valid,
   input  wire logic       gain_control_pulse,
   output int              byte_count,
   output int              byte_sum,
   output int              last_period,
   output int              last_width
);
   int   since_rise;
   int   width;
   logic prev;
   always_ff @(posedge clk) begin
      if (rst) begin
         byte_count <= 0;
         byte_sum <= 0;
      end else if (rx_out_valid === 1'b1) begin
         byte_count <= byte_count + 1;
         byte_sum <= byte_sum + int'(rx_out_byte);
      end
   end
   always_ff @(posedge clk) begin
      prev <= gain_control_pulse;
      if (rst) begin
         since_rise <= 0;
         width <= 0;
         last_period <= 0;
         last_width <= 0;
      end else if (gain_control_pulse === 1'b1 && prev === 1'b0) begin
         last_period <= since_rise;
         last_width <= width;
         since_rise <= 1;
         width <= 1;
      end else begin
         since_rise <= since_rise + 1;
         width <= width + int'(gain_control_pulse === 1'b1);
      end
   end
endmodule
`default_nettype wire

// >>> sim/cls_carrier_loop_tb_top.sv
// Self-checking testbench of the carrier loop sequencer and output statistics.
`timescale 1ns/1ps
`include "cls_consts.svh"
`default_nettype none
module cls_carrier_loop_tb_top;
   import cls_pkg::*;
   localparam int PS = 4;
   localparam int PL = 8;
   logic        clk, rst, restart, tlock, rx_valid, terr, rs_valid, irq, locked;
   logic        eq_cm, phold, rx_out_valid, gcp;
   logic [7:0]  rx_in, rs_add, level, bus_rdata, rdata, scan_offset, rx_out_byte;
   logic [2:0]  state;
   logic [3:0]  shift;
   logic [15:0] te_est, rs_hi, rs_lo;
   cls_cfg_t    cfg;
   cls_ev_t     ev;
   cls_bus_t    bus;
   cls_bw_t     loop_bw;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          s_count, s_sum, s_period, s_width;

   cls_carrier_loop #(.INIT_SHORT_SYMS(PS), .INIT_LONG_SYMS(PL)) u_dut (
      .clk(clk), .rst(rst), .restart(restart), .timing_loop_locked(tlock), .cfg(cfg),
      .ev(ev), .bus(bus), .rx_byte_in(rx_in), .rx_byte_valid_in(rx_valid),
      .trellis_error(terr), .rs_corr_valid(rs_valid), .rs_corr_add(rs_add),
      .signal_level(level), .bus_rdata(bus_rdata), .irq(irq), .carrier_loop_state(state),
      .carrier_loop_locked(locked), .eq_constmod(eq_cm), .eq_step_shift(shift),
      .loop_bw(loop_bw), .phase_error_hold(phold), .scan_offset(scan_offset),
      .rx_out_byte(rx_out_byte), .rx_out_valid(rx_out_valid),
      .trellis_error_estimate(te_est), .rs_corrected_count_hi(rs_hi),
      .rs_corrected_count_lo(rs_lo), .gain_control_pulse(gcp));

   cls_sink_model u_sink (
      .clk(clk), .rst(rst), .rx_out_byte(rx_out_byte), .rx_out_valid(rx_out_valid),
      .gain_control_pulse(gcp), .byte_count(s_count), .byte_sum(s_sum),
      .last_period(s_period), .last_width(s_width));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic bus_rd(input logic [1:0] a);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
      #1;
      rdata = bus_rdata;
   endtask

   task automatic pulse(input logic [3:0] b);
      @(posedge clk);
      ev <= cls_ev_t'(b);
      @(posedge clk);
      ev <= '0;
   endtask

   task automatic wait_code(input logic [2:0] code, input int lim);
      int n;
      n = 0;
      while (state !== code && n < lim) begin
         tick(1);
         n++;
      end
      chk(state, code);
   endtask

   task automatic run_acq(input logic [1:0] i);
      logic il, afc;
      int   n, per;
      logic [7:0] off;
      il = i[0];
      afc = ~i[1];
      @(posedge clk);
      cfg <= '{il, afc, il, 1'($urandom), 1'($urandom), i, ~i};
      tlock <= 1'b0;
      restart <= 1'b1;
      tick(3);
      @(posedge clk);
      restart <= 1'b0;
      tick(4);
      chk(state, `CLS_CODE_IDLE);
      chk(locked, 1'b0);
      chk(eq_cm, 1'b0);
      chk(phold, 1'b1);
      @(posedge clk);
      tlock <= 1'b1;
      wait_code(`CLS_CODE_INIT, 6);
      chk(eq_cm, 1'b1);
      chk(shift, `CLS_CMA_SHIFT_BASE - cfg.step_constmod);
      per = il ? 2 * PL : 2 * PS;
      n = 0;
      while (state === `CLS_CODE_INIT && n < 100) begin
         tick(1);
         n++;
      end
      chk(n >= per - 1 && n <= per + 2, 1'b1);
      chk(state, afc ? `CLS_CODE_AFC : `CLS_CODE_SCAN);
      if (afc) begin
         repeat ((il ? `CLS_AFC_AVG_LONG : `CLS_AFC_AVG_SHORT) - 1) pulse(4'h8);
         tick(4);
         chk(state, `CLS_CODE_AFC);
         pulse(4'h8);
      end
      wait_code(`CLS_CODE_CORNER, 8);
      chk(loop_bw, {1'b0, cfg.pullin_wide});
      if (!afc) begin
         off = scan_offset;
         pulse(4'h2);
         tick(6);
         chk(scan_offset, off + 8'h01);
         wait_code(`CLS_CODE_CORNER, 8);
      end
      pulse(4'h4);
      wait_code(`CLS_CODE_DDPULL, 8);
      chk(eq_cm, 1'b1);
      pulse(4'h4);
      wait_code(`CLS_CODE_LOCK, 8);
      tick(3);
      chk(locked, 1'b1);
      chk(phold, 1'b0);
      chk(eq_cm, 1'b0);
      chk(shift, `CLS_DD_SHIFT_BASE - cfg.step_decision);
      chk(loop_bw, {1'b1, cfg.tracking_wide});
      chk(irq, 1'b1);
      bus_rd(`CLS_ADDR_STATUS);
      chk(rdata & 8'h01, 8'h01);
      bus_wr(`CLS_ADDR_ENABLE, 8'h00);
      tick(2);
      chk(irq, 1'b0);
      bus_wr(`CLS_ADDR_ENABLE, 8'h01);
      tick(2);
      chk(irq, 1'b1);
      bus_wr(`CLS_ADDR_CLEAR, 8'h01);
      tick(2);
      chk(irq, 1'b0);
      bus_rd(`CLS_ADDR_STATUS);
      chk(rdata, {5'h0, i[1], |i, 1'b0});
      pulse(4'h1);
      wait_code(afc ? `CLS_CODE_AFC : `CLS_CODE_SCAN, 8);
      $display("test acquisition %0d done", i);
   endtask

   initial begin
      logic       pv, nv, nt;
      logic [7:0] pb, nb, na;
      int         tcount, rsum, vcount, bsum, lv;
      {restart, tlock, rx_valid, terr, rs_valid, rx_in, rs_add, level} = '0;
      {cfg, ev, bus} = '0;
      rst = 1'b1;
      void'($urandom(32'h797879d6));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      bus_wr(`CLS_ADDR_ENABLE, 8'h01);
      bus_rd(`CLS_ADDR_ENABLE);
      chk(rdata, 8'h01);
      tick(1);
      chk(bus_rdata, 8'h00);
      bus_rd(2'h3);
      chk(rdata, 8'h00);
      {pv, pb, tcount, rsum, vcount, bsum} = '0;
      for (int i = 0; i < 300; i++) begin
         nb = 8'($urandom);
         nv = (i < 299) ? 1'($urandom) : 1'b0;
         nt = (i < 299) ? 1'($urandom) : 1'b0;
         na = (i < 299) ? 8'($urandom_range(200, 255)) : 8'h00;
         @(posedge clk);
         rx_in <= nb;
         rx_valid <= nv;
         terr <= nt;
         rs_valid <= (i < 299);
         rs_add <= na;
         tcount += int'(nt);
         rsum += int'(na);
         #1;
         chk(rx_out_valid, pv);
         if (pv)
            chk(rx_out_byte, pb);
         vcount += int'(nv);
         bsum += nv ? int'(nb) : 0;
         pv = nv;
         pb = nb;
      end
      tick(3);
      chk(te_est, tcount);
      chk({rs_hi, rs_lo}, rsum);
      chk(s_count, vcount);
      chk(s_sum, bsum);
      $display("test data path done");
      for (int k = 0; k < 2; k++) begin
         lv = k ? $urandom_range(1, 254) : 255;
         @(posedge clk);
         level <= 8'(lv);
         tick(1600);
         chk(s_period, 2 * `CLS_AGC_PERIOD_SYMS);
         chk(s_width, 2 * lv);
      end
      $display("test gain pulse done");
      for (int i = 0; i < 4; i++)
         run_acq(2'(i));
      close_out();
   end
endmodule
`default_nettype wire
